// File: hw/plldld_defs.svh
// register map, field positions, reset values and timing figures of the lock detector
`ifndef PLLDLD_DEFS_SVH
`define PLLDLD_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define PLLDLD_ADDR_W 10
`define PLLDLD_OFS_ABL_CFG 10'h017
`define PLLDLD_OFS_REF_LD_CFG 10'h018
`define PLLDLD_OFS_LOCK_STAT 10'h01e
`define PLLDLD_OFS_IRQ_STAT 10'h01f
`define PLLDLD_OFS_IRQ_MASK 10'h020

// ****************************************
// field positions and reset values
// ****************************************
`define PLLDLD_ABL_LSB 0
`define PLLDLD_ABL_MSB 1
`define PLLDLD_DC_OFS_BIT 7
`define PLLDLD_CNT_LSB 5
`define PLLDLD_CNT_MSB 6
`define PLLDLD_WIN_BIT 4
`define PLLDLD_ABL_RST 8'h00
`define PLLDLD_REF_LD_RST 8'h00
`define PLLDLD_IRQ_MASK_RST 8'h00
`define PLLDLD_IRQ_ACQ_BIT 0
`define PLLDLD_IRQ_LOST_BIT 1

// ****************************************
// lock run lengths in comparator cycles
// ****************************************
`define PLLDLD_RUN_C0 8'h05
`define PLLDLD_RUN_C1 8'h10
`define PLLDLD_RUN_C2 8'h40
`define PLLDLD_RUN_C3 8'hff

// ****************************************
// times in picoseconds
// ****************************************
`define PLLDLD_ABL_C1_PS 16'h0514
`define PLLDLD_ABL_C2_PS 16'h1770
`define PLLDLD_ABL_C3_PS 16'h0b54
`define PLLDLD_WIN_HIGH_PS 16'h0dac
`define PLLDLD_WIN_LOW_PS 16'h05dc
`define PLLDLD_LOSS_HIGH_PS 16'h1b58
`define PLLDLD_LOSS_LOW_PS 16'h0bb8

`endif

// File: hw/plldld_pkg.sv
// types shared by the lock detector modules
package plldld_pkg;
  typedef logic [7:0] plldld_byte_t;
  typedef logic [15:0] plldld_ps_t;
  typedef enum logic [1:0] {
    plldld_run5,
    plldld_run16,
    plldld_run64,
    plldld_run255
  } plldld_run_t;
  typedef enum {
    plldld_st_search,
    plldld_st_locked
  } plldld_state_t;
endpackage : plldld_pkg

// File: hw/plldld_cmp_if.sv
// carrier between the lock state logic and the window comparator
`timescale 1ns/1ps
interface plldld_cmp_if;
  import plldld_pkg::*;
  plldld_ps_t edge_diff_ps;
  logic low_range;
  logic in_window;
  logic beyond_loss;
  modport ctrl (output edge_diff_ps, output low_range, input in_window, input beyond_loss);
  modport cmp (input edge_diff_ps, input low_range, output in_window, output beyond_loss);
endinterface : plldld_cmp_if

// File: hw/plldld_window_cmp.sv
// compares one edge time difference against the lock window and loss threshold
`timescale 1ns/1ps
`include "plldld_defs.svh"
module plldld_window_cmp #(
  parameter int WIN_HIGH_PS = `PLLDLD_WIN_HIGH_PS,
  parameter int WIN_LOW_PS = `PLLDLD_WIN_LOW_PS,
  parameter int LOSS_HIGH_PS = `PLLDLD_LOSS_HIGH_PS,
  parameter int LOSS_LOW_PS = `PLLDLD_LOSS_LOW_PS
) (
  plldld_cmp_if.cmp cmp_port
);
  import plldld_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  // hysteresis needs the loss threshold strictly above the window
  if (WIN_LOW_PS < 1 || WIN_LOW_PS > WIN_HIGH_PS || LOSS_HIGH_PS <= WIN_HIGH_PS ||
      LOSS_LOW_PS <= WIN_LOW_PS || LOSS_HIGH_PS > 65535 || LOSS_LOW_PS > 65535) begin : g_bad
    $error("plldld_window_cmp: window and loss thresholds out of range");
  end

  // ****************************************
  // threshold selection
  // ****************************************
  localparam plldld_ps_t WIN_HI = plldld_ps_t'(WIN_HIGH_PS);
  localparam plldld_ps_t WIN_LO = plldld_ps_t'(WIN_LOW_PS);
  localparam plldld_ps_t LOSS_HI = plldld_ps_t'(LOSS_HIGH_PS);
  localparam plldld_ps_t LOSS_LO = plldld_ps_t'(LOSS_LOW_PS);

  wire plldld_ps_t win_sel = cmp_port.low_range ? WIN_LO : WIN_HI;
  wire plldld_ps_t loss_sel = cmp_port.low_range ? LOSS_LO : LOSS_HI;

  assign cmp_port.in_window = cmp_port.edge_diff_ps < win_sel;
  assign cmp_port.beyond_loss = cmp_port.edge_diff_ps > loss_sel;
endmodule : plldld_window_cmp

// File: hw/plldld_top.sv
// digital lock detector with reference and antibacklash configuration registers
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "plldld_defs.svh"

// Behaviour
// - two-bit antibacklash code selects default, 1.3, 6.0 or 2.9 ns pulse
// - bit 7 of reference config enables cmos reference dc offset; default off
// - lock asserts only after a run of consecutive in-window comparator cycles
// - counter code gives run of 5, 16, 64 or 255 cycles; default 5
// - lock flag sets when edge difference is below selected window time
// - lock stays set until edge difference exceeds the loss threshold
// - bit 4 picks window range: 0 high 3.5 ns default, 1 low
module plldld_top #(
  parameter int WIN_LOW_PS = `PLLDLD_WIN_LOW_PS,
  parameter int LOSS_HIGH_PS = `PLLDLD_LOSS_HIGH_PS,
  parameter int LOSS_LOW_PS = `PLLDLD_LOSS_LOW_PS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`PLLDLD_ADDR_W-1:0] reg_addr,
  input wire plldld_pkg::plldld_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output plldld_pkg::plldld_byte_t reg_rdata,
  input wire logic pfd_cycle,
  input wire plldld_pkg::plldld_ps_t pfd_edge_diff_ps,
  output logic lock_flag_digital,
  output logic [1:0] abl_width_code,
  output plldld_pkg::plldld_ps_t abl_width_ps,
  output logic cmos_ref_dc_offset_en,
  output logic irq
);
  import plldld_pkg::*;

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic plldld_byte_t run_length(input plldld_run_t code);
    case (code)
      plldld_run5: run_length = `PLLDLD_RUN_C0;
      plldld_run16: run_length = `PLLDLD_RUN_C1;
      plldld_run64: run_length = `PLLDLD_RUN_C2;
      plldld_run255: run_length = `PLLDLD_RUN_C3;
      default: run_length = `PLLDLD_RUN_C0;
    endcase
  endfunction : run_length

  // zero stands for the analog default width, which has no digital figure
  function automatic plldld_ps_t abl_ps(input logic [1:0] code);
    case (code)
      2'h1: abl_ps = `PLLDLD_ABL_C1_PS;
      2'h2: abl_ps = `PLLDLD_ABL_C2_PS;
      2'h3: abl_ps = `PLLDLD_ABL_C3_PS;
      default: abl_ps = 16'h0000;
    endcase
  endfunction : abl_ps

  // ****************************************
  // registers and state
  // ****************************************
  plldld_byte_t abl_cfg_reg;
  plldld_byte_t ref_ld_cfg_reg;
  plldld_byte_t irq_stat_reg;
  plldld_byte_t irq_stat_next;
  plldld_byte_t irq_mask_reg;
  plldld_byte_t rdata_reg;
  plldld_byte_t run_cnt_reg;
  plldld_byte_t run_cnt_next;
  plldld_state_t state_reg;
  plldld_state_t state_next;
  logic [1:0] abl_code_reg;
  plldld_ps_t abl_ps_reg;
  logic dc_ofs_reg;

  // ****************************************
  // address decode
  // ****************************************
  wire hit_abl = reg_addr == `PLLDLD_OFS_ABL_CFG;
  wire hit_ref = reg_addr == `PLLDLD_OFS_REF_LD_CFG;
  wire hit_lstat = reg_addr == `PLLDLD_OFS_LOCK_STAT;
  wire hit_istat = reg_addr == `PLLDLD_OFS_IRQ_STAT;
  wire hit_imask = reg_addr == `PLLDLD_OFS_IRQ_MASK;
  wire istat_read = reg_rd && hit_istat;

  // ****************************************
  // window comparator
  // ****************************************
  plldld_cmp_if cmp_bus ();

  assign cmp_bus.edge_diff_ps = pfd_edge_diff_ps;
  assign cmp_bus.low_range = ref_ld_cfg_reg[`PLLDLD_WIN_BIT];

  plldld_window_cmp #(
    .WIN_HIGH_PS(`PLLDLD_WIN_HIGH_PS),
    .WIN_LOW_PS(WIN_LOW_PS),
    .LOSS_HIGH_PS(LOSS_HIGH_PS),
    .LOSS_LOW_PS(LOSS_LOW_PS)
  ) u_cmp (
    .cmp_port(cmp_bus.cmp)
  );

  // ****************************************
  // lock run counter and state
  // ****************************************
  wire plldld_run_t run_code = plldld_run_t'(ref_ld_cfg_reg[`PLLDLD_CNT_MSB:`PLLDLD_CNT_LSB]);
  wire plldld_byte_t run_target = run_length(run_code);
  wire good_cycle = pfd_cycle && cmp_bus.in_window;
  wire bad_cycle = pfd_cycle && !cmp_bus.in_window;
  wire run_done = good_cycle && (run_cnt_reg >= run_target - 8'h01);
  wire lose_lock = pfd_cycle && cmp_bus.beyond_loss;

  // count saturates at the target so a long lock cannot wrap it
  always_comb begin
    run_cnt_next = run_cnt_reg;
    if (bad_cycle) begin
      run_cnt_next = 8'h00;
    end else if (good_cycle && run_cnt_reg < run_target) begin
      run_cnt_next = run_cnt_reg + 8'h01;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      plldld_st_search: begin
        if (run_done) begin
          state_next = plldld_st_locked;
        end
      end
      plldld_st_locked: begin
        // between window and loss threshold the flag holds
        if (lose_lock) begin
          state_next = plldld_st_search;
        end
      end
      default: state_next = plldld_st_search;
    endcase
  end

  wire ev_acq = state_reg == plldld_st_search && state_next == plldld_st_locked;
  wire ev_lost = state_reg == plldld_st_locked && state_next == plldld_st_search;

  // ****************************************
  // interrupt status
  // ****************************************
  // a new event in the clearing read's cycle still survives
  always_comb begin
    irq_stat_next = istat_read ? 8'h00 : irq_stat_reg;
    if (ev_acq) begin
      irq_stat_next[`PLLDLD_IRQ_ACQ_BIT] = 1'b1;
    end
    if (ev_lost) begin
      irq_stat_next[`PLLDLD_IRQ_LOST_BIT] = 1'b1;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  wire plldld_byte_t lock_stat = {6'h00, state_reg == plldld_st_locked, run_cnt_reg == run_target};
  wire plldld_byte_t rd_mux = hit_abl ? abl_cfg_reg :
                              hit_ref ? ref_ld_cfg_reg :
                              hit_lstat ? lock_stat :
                              hit_istat ? irq_stat_reg :
                              hit_imask ? irq_mask_reg : 8'h00;

  // ****************************************
  // clocked state
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      abl_cfg_reg <= `PLLDLD_ABL_RST;
      ref_ld_cfg_reg <= `PLLDLD_REF_LD_RST;
      irq_mask_reg <= `PLLDLD_IRQ_MASK_RST;
    end else if (reg_wr) begin
      if (hit_abl) begin
        abl_cfg_reg <= reg_wdata;
      end
      if (hit_ref) begin
        ref_ld_cfg_reg <= reg_wdata;
      end
      if (hit_imask) begin
        irq_mask_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      run_cnt_reg <= 8'h00;
      state_reg <= plldld_st_search;
      irq_stat_reg <= 8'h00;
    end else begin
      run_cnt_reg <= run_cnt_next;
      state_reg <= state_next;
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      abl_code_reg <= 2'h0;
      abl_ps_reg <= 16'h0000;
      dc_ofs_reg <= 1'b0;
    end else begin
      abl_code_reg <= abl_cfg_reg[`PLLDLD_ABL_MSB:`PLLDLD_ABL_LSB];
      abl_ps_reg <= abl_ps(abl_cfg_reg[`PLLDLD_ABL_MSB:`PLLDLD_ABL_LSB]);
      dc_ofs_reg <= ref_ld_cfg_reg[`PLLDLD_DC_OFS_BIT];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = rdata_reg;
  assign lock_flag_digital = state_reg == plldld_st_locked;
  assign abl_width_code = abl_code_reg;
  assign abl_width_ps = abl_ps_reg;
  assign cmos_ref_dc_offset_en = dc_ofs_reg;
  assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule : plldld_top

// File: bench/plldld_asserts.sv
// port checker of the lock detector
`timescale 1ns/1ps
`include "plldld_defs.svh"
// ****
// checker
// ****
module plldld_chk #(
  parameter int WIN_LOW_PS = `PLLDLD_WIN_LOW_PS,
  parameter int LOSS_HIGH_PS = `PLLDLD_LOSS_HIGH_PS,
  parameter int LOSS_LOW_PS = `PLLDLD_LOSS_LOW_PS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`PLLDLD_ADDR_W-1:0] reg_addr,
  input wire plldld_pkg::plldld_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire plldld_pkg::plldld_byte_t reg_rdata,
  input wire logic pfd_cycle,
  input wire plldld_pkg::plldld_ps_t pfd_edge_diff_ps,
  input wire logic lock_flag_digital,
  input wire logic [1:0] abl_width_code,
  input wire plldld_pkg::plldld_ps_t abl_width_ps,
  input wire logic cmos_ref_dc_offset_en
);
  import plldld_pkg::*;
  logic [7:0] cfg_reg;
  logic [7:0] run_reg;
  logic [7:0] tgt;
  logic inwin;
  logic beyond;
  // shadow of the config so window and run length are known here
  assign tgt = cfg_reg[6:5] == 2'h0 ? 8'h05 : cfg_reg[6:5] == 2'h1 ? 8'h10 : cfg_reg[6:5] == 2'h2 ? 8'h40 : 8'hff;
  assign inwin = pfd_edge_diff_ps < (cfg_reg[4] ? WIN_LOW_PS : `PLLDLD_WIN_HIGH_PS);
  assign beyond = pfd_edge_diff_ps > (cfg_reg[4] ? LOSS_LOW_PS : LOSS_HIGH_PS);
  always_ff @(posedge clk) begin
    if (srst) cfg_reg <= 8'h00;
    else if (reg_wr && reg_addr == `PLLDLD_OFS_REF_LD_CFG) cfg_reg <= reg_wdata;
  end
  // saturates at 255, only its value just below target matters
  always_ff @(posedge clk) begin
    if (srst) run_reg <= 8'h00;
    else if (pfd_cycle) run_reg <= !inwin ? 8'h00 : run_reg == 8'hff ? run_reg : run_reg + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_abl_wr;
    reg_wr && reg_addr == `PLLDLD_OFS_ABL_CFG;
  endsequence
  sequence s_ref_wr;
    reg_wr && reg_addr == `PLLDLD_OFS_REF_LD_CFG;
  endsequence
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_abl_map: assert property (abl_width_ps == (abl_width_code == 2'h1 ? 16'h0514 : abl_width_code == 2'h2 ?
    16'h1770 : abl_width_code == 2'h3 ? 16'h0b54 : 16'h0000)) else $error("antibacklash width wrong");
  a_abl_follow: assert property (s_abl_wr |-> ##2 abl_width_code == $past(reg_wdata[1:0], 2))
    else $error("antibacklash code not taken");
  a_dc_follow: assert property (s_ref_wr |-> ##2 cmos_ref_dc_offset_en == $past(reg_wdata[7], 2))
    else $error("dc offset enable not taken");
  a_lock_rise: assert property ($rose(lock_flag_digital) |-> $past(pfd_cycle && inwin && run_reg == tgt - 8'h01))
    else $error("lock without full in-window run");
  a_lock_fall: assert property ($fell(lock_flag_digital) |-> $past(pfd_cycle && beyond))
    else $error("lock dropped below loss threshold");
  a_lock_hold: assert property (lock_flag_digital && !(pfd_cycle && beyond) |=> lock_flag_digital)
    else $error("lock not held");
  a_lock_lose: assert property (lock_flag_digital && pfd_cycle && beyond |=> !lock_flag_digital)
    else $error("lock kept past loss threshold");
endmodule : plldld_chk
bind plldld_top plldld_chk #(.WIN_LOW_PS(WIN_LOW_PS), .LOSS_HIGH_PS(LOSS_HIGH_PS), .LOSS_LOW_PS(LOSS_LOW_PS)) chk_u (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pfd_cycle(pfd_cycle), .pfd_edge_diff_ps(pfd_edge_diff_ps),
  .lock_flag_digital(lock_flag_digital), .abl_width_code(abl_width_code), .abl_width_ps(abl_width_ps),
  .cmos_ref_dc_offset_en(cmos_ref_dc_offset_en));

// File: bench/plldld_bench.sv
// self-checking bench of the lock detector
`timescale 1ns/1ps
module plldld_bench;
  import plldld_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] reg_addr = 10'h000;
  plldld_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pfd_cycle = 1'b0;
  plldld_ps_t pfd_edge_diff_ps = 16'h0000;
  plldld_byte_t reg_rdata;
  logic lock_flag_digital;
  logic [1:0] abl_width_code;
  plldld_ps_t abl_width_ps;
  logic cmos_ref_dc_offset_en;
  logic irq;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int tgt [4] = '{5, 16, 64, 255};
  plldld_ps_t abl_ps [4] = '{16'h0000, 16'h0514, 16'h1770, 16'h0b54};
  plldld_top dut_u (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pfd_cycle(pfd_cycle), .pfd_edge_diff_ps(pfd_edge_diff_ps),
    .lock_flag_digital(lock_flag_digital), .abl_width_code(abl_width_code), .abl_width_ps(abl_width_ps),
    .cmos_ref_dc_offset_en(cmos_ref_dc_offset_en), .irq(irq));
  initial begin
    forever #25 clk = ~clk;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input plldld_byte_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [9:0] a, input plldld_byte_t e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(e));
  endtask : rd
  // back-to-back comparator pulses, ends just after the last one is taken
  task automatic phase_freq_comparator(input plldld_ps_t d, input int n);
    repeat (n) begin
      @(posedge clk);
      pfd_cycle <= 1'b1;
      pfd_edge_diff_ps <= d;
    end
    @(posedge clk);
    pfd_cycle <= 1'b0;
    #1;
  endtask : phase_freq_comparator
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // hang guard, the tests need about 820 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(10'h017, 8'h00);
    rd(10'h018, 8'h00);
    wr(10'h01e, 8'hff);
    rd(10'h01e, 8'h00);
    rd(10'h100, 8'h00);
    chk(16'(irq), 16'h0000);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      wr(10'h017, 8'(c));
      @(posedge clk);
      #1;
      chk(16'(abl_width_code), 16'(c));
      chk(abl_width_ps, abl_ps[c]);
      rd(10'h017, 8'(c));
    end
    for (int b = 1; b >= 0; b--) begin
      wr(10'h018, 8'(b << 7));
      @(posedge clk);
      #1;
      chk(16'(cmos_ref_dc_offset_en), 16'(b));
    end
    $display("test config done");
    wr(10'h020, 8'h03);
    for (int c = 0; c < 4; c++) begin
      wr(10'h018, 8'(c << 5));
      phase_freq_comparator(16'h0064, tgt[c] - 1);
      phase_freq_comparator(16'h0fa0, 1);
      phase_freq_comparator(16'h0064, tgt[c] - 1);
      chk(16'(lock_flag_digital), 16'h0000);
      phase_freq_comparator(16'h0064, 1);
      chk(16'(lock_flag_digital), 16'h0001);
      chk(16'(irq), 16'h0001);
      rd(10'h01e, 8'h03);
      rd(10'h01f, 8'h01);
      chk(16'(irq), 16'h0000);
      phase_freq_comparator(16'h1f40, 1);
      chk(16'(lock_flag_digital), 16'h0000);
      rd(10'h01f, 8'h02);
    end
    $display("test run length done");
    wr(10'h018, 8'h00);
    wr(10'h020, 8'h00);
    phase_freq_comparator(16'h0dab, 5);
    chk(16'(lock_flag_digital), 16'h0001);
    chk(16'(irq), 16'h0000);
    phase_freq_comparator(16'h0dac, 1);
    phase_freq_comparator(16'h1b58, 1);
    chk(16'(lock_flag_digital), 16'h0001);
    wr(10'h020, 8'h01);
    chk(16'(irq), 16'h0001);
    rd(10'h01f, 8'h01);
    wr(10'h018, 8'h10);
    phase_freq_comparator(16'h0bb9, 1);
    chk(16'(lock_flag_digital), 16'h0000);
    phase_freq_comparator(16'h0064, 4);
    phase_freq_comparator(16'h05dc, 1);
    phase_freq_comparator(16'h0064, 4);
    chk(16'(lock_flag_digital), 16'h0000);
    phase_freq_comparator(16'h05db, 1);
    chk(16'(lock_flag_digital), 16'h0001);
    $display("test hysteresis done");
    summarize();
  end
endmodule : plldld_bench
